//--- design/eer_read_path.sv
// Purpose: Two-wire serial EEPROM target, read side, with dummy-write addressing.
// Assumes: Array bytes come from a memory port on clk_sys; the link logic oversamples the bus on clk_link.
// Notes:   Each clock domain keeps its state, bar its reset synchronizer, in one struct; they meet only through a toggle handshake.
//
// Function
// - Read equals write except direction bit one.
// - Pointer holds last accessed address plus one.
// - Pointer survives between transactions.
// - Main array read wraps last byte to first.
// - After read address acknowledge, shift byte out.
// - Dummy write acknowledged, loads pointer, read follows.
// - Controller acknowledge advances pointer, next byte out.
// - Word address bit nine selects ID bytes.
// - ID pointer wraps after sixteenth byte.
// - Bits ten, nine zero select security sector.
// - Sector pointer advances per byte and wraps.
// - Sector write probe acknowledges only when unlocked.
// - Start discards command; stop returns to standby.
// - Lock status byte bit one shows lock.
// - Lock status byte repeats every acknowledged slot.
// - Code 1010 plus chip select picks array.
// - Code 1011 plus chip select picks extras.
// - Two word address bytes, high first, acknowledged.
// - Bits ten, nine equal 10 select lock flag.
`timescale 1ns/1ns
`include "eer_params.svh"
module eer_read_path (
   input  wire logic                     clk_sys,
   input  wire logic                     reset,
   input  wire logic                     clk_link,
   input  wire logic                     scl_in,
   input  wire logic                     sda_in,
   output logic                          sda_out,
   output logic                          sda_oe_n,
   input  wire logic                     chip_select_bit2,
   input  wire logic                     chip_select_lock_flag_bit,
   input  wire logic                     chip_select_bit0,
   input  wire logic                     sector_locked,
   output logic                          mem_rd_en,
   output eer_pkg::eer_area_type         mem_rd_area,
   output logic [`EER_ADDR_W-1:0]        mem_rd_addr,
   input  wire logic [`EER_BYTE_W-1:0]   mem_rd_data
);

   // Writes roll within their page; the upper address bits never move.
   function automatic logic [`EER_ADDR_W-1:0] eer_page_inc(input logic [`EER_ADDR_W-1:0] a);
      eer_page_inc = {a[`EER_ADDR_W-1:`EER_PAGE_W], `EER_PAGE_W'(a[`EER_PAGE_W-1:0] + 1'b1)};
   endfunction : eer_page_inc

   function automatic logic [`EER_ADDR_W-1:0] eer_area_addr(input eer_pkg::eer_area_type ar,
                                                            input logic [`EER_ADDR_W-1:0] mp,
                                                            input logic [`EER_SEC_W-1:0] sp,
                                                            input logic [`EER_UID_W-1:0] up);
      case (ar)
         eer_pkg::area_sector: eer_area_addr = `EER_ADDR_W'(sp);
         eer_pkg::area_uid:    eer_area_addr = `EER_ADDR_W'(up);
         eer_pkg::area_main:   eer_area_addr = mp;
         default:              eer_area_addr = '0;
      endcase
   endfunction : eer_area_addr

   // The extras code selects identifier, sector and lock flag instead of the array.
   function automatic logic eer_is_special(input logic [`EER_BYTE_W-1:0] b);
      eer_is_special = (b[`EER_BYTE_W-1:`EER_CODE_LSB] == `EER_CODE_SPECIAL);
   endfunction : eer_is_special

   function automatic logic eer_is_main(input logic [`EER_BYTE_W-1:0] b);
      eer_is_main = (b[`EER_BYTE_W-1:`EER_CODE_LSB] == `EER_CODE_MAIN);
   endfunction : eer_is_main

   eer_pkg::eer_link_type q;
   eer_pkg::eer_link_type n;
   eer_pkg::eer_sys_type  qs;
   eer_pkg::eer_sys_type  ns;

   logic                     scl_rise;
   logic                     scl_fall;
   logic                     bus_start;
   logic                     bus_stop;
   logic                     dev_match;
   logic                     byte_done;
   logic                     wr_ack;
   logic [`EER_ADDR_W-1:0]   full_addr;
   logic [`EER_ADDR_W-1:0]   nxt_main;
   logic [`EER_SEC_W-1:0]    nxt_sec;
   logic [`EER_UID_W-1:0]    nxt_uid;
   logic [`EER_BYTE_W-1:0]   lock_byte;
   logic [`EER_BYTE_W-1:0]   tx_byte;
   logic [1:0]               link_rst_ff;
   logic [1:0]               sys_rst_ff;
   logic                     link_rst;
   logic                     sys_rst;

   // Edges are taken from the second and third stages so the first stage feeds nothing else.
   assign scl_rise  = q.scl_s2 & ~q.scl_s3;
   assign scl_fall  = ~q.scl_s2 & q.scl_s3;
   assign bus_start = q.scl_s2 & q.scl_s3 & q.sda_s3 & ~q.sda_s2;
   assign bus_stop  = q.scl_s2 & q.scl_s3 & ~q.sda_s3 & q.sda_s2;
   assign byte_done = scl_fall & (q.bit_cnt == `EER_BITS_PER_BYTE);
   assign full_addr = {q.waddr_hi, q.shreg};

   assign dev_match = (eer_is_main(q.shreg) | eer_is_special(q.shreg)) &
                      (q.shreg[`EER_CODE_LSB-1:`EER_CS_LSB] == q.cs_s2);

   always_comb begin
      lock_byte = '0;
      lock_byte[`EER_LOCK_BIT] = q.lock_s2;
   end

   // A lock status read never fetches; its byte is built here from the synchronised flag.
   assign tx_byte = (q.rd_area == eer_pkg::area_lock) ? lock_byte : q.fetched;

   always_comb begin
      nxt_main = q.main_ptr;
      nxt_sec  = q.sec_ptr;
      nxt_uid  = q.uid_ptr;
      case (q.rd_area)
         eer_pkg::area_main:   nxt_main = `EER_ADDR_W'(q.main_ptr + 1'b1);
         eer_pkg::area_sector: nxt_sec  = `EER_SEC_W'(q.sec_ptr + 1'b1);
         eer_pkg::area_uid:    nxt_uid  = `EER_UID_W'(q.uid_ptr + 1'b1);
         default:              nxt_main = q.main_ptr;
      endcase
   end

   // Data bytes of a sector or lock write are refused while the sector is locked.
   assign wr_ack = ~(q.special & q.lock_s2 & (q.spec_area != eer_pkg::area_uid));

   always_comb begin
      n = q;
      n.scl_s1  = scl_in;
      n.scl_s2  = q.scl_s1;
      n.scl_s3  = q.scl_s2;
      n.sda_s1  = sda_in;
      n.sda_s2  = q.sda_s1;
      n.sda_s3  = q.sda_s2;
      n.cs_s1   = {chip_select_bit2, chip_select_lock_flag_bit, chip_select_bit0};
      n.cs_s2   = q.cs_s1;
      n.lock_s1 = sector_locked;
      n.lock_s2 = q.lock_s1;
      n.ack_s1  = qs.ack_t;
      n.ack_s2  = q.ack_s1;
      n.ack_s3  = q.ack_s2;
      if (q.ack_s2 != q.ack_s3) begin
         n.fetched = qs.rdata;
      end
      if (bus_start) begin
         n.state    = eer_pkg::st_dev;
         n.bit_cnt  = '0;
         n.sda_oe_n = 1'b1;
      end else if (bus_stop) begin
         n.state    = eer_pkg::st_idle;
         n.sda_oe_n = 1'b1;
      end else begin
         case (q.state)
            eer_pkg::st_idle: begin
               n.sda_oe_n = 1'b1;
            end
            eer_pkg::st_dev, eer_pkg::st_rx: begin
               if (scl_rise) begin
                  n.shreg   = {q.shreg[`EER_BYTE_W-2:0], q.sda_s2};
                  n.bit_cnt = `EER_CNT_W'(q.bit_cnt + `EER_CNT_ONE);
               end else if (byte_done && q.state == eer_pkg::st_dev) begin
                  n.bit_cnt  = '0;
                  n.byte_idx = `EER_IDX_HI;
                  if (dev_match) begin
                     n.state    = eer_pkg::st_dev_ack;
                     n.sda_oe_n = 1'b0;
                     n.special  = eer_is_special(q.shreg);
                     n.rd_area  = eer_is_special(q.shreg) ? q.spec_area : eer_pkg::area_main;
                     if (q.shreg[`EER_RW_BIT] && n.rd_area != eer_pkg::area_lock) begin
                        n.req_t    = ~q.req_t;
                        n.req_area = n.rd_area;
                        n.req_addr = eer_area_addr(n.rd_area, q.main_ptr, q.sec_ptr, q.uid_ptr);
                     end
                  end else begin
                     n.state = eer_pkg::st_wait;
                  end
               end else if (byte_done) begin
                  n.bit_cnt  = '0;
                  n.state    = eer_pkg::st_rx_ack;
                  n.sda_oe_n = 1'b0;
                  case (q.byte_idx)
                     `EER_IDX_HI: begin
                        n.waddr_hi = q.shreg;
                        n.byte_idx = `EER_IDX_LO;
                     end
                     `EER_IDX_LO: begin
                        n.byte_idx = `EER_IDX_DATA;
                        if (!q.special) begin
                           n.main_ptr = full_addr;
                        end else if (full_addr[`EER_SEL_UID]) begin
                           n.spec_area = eer_pkg::area_uid;
                           n.uid_ptr   = full_addr[`EER_UID_MSB:0];
                        end else if (full_addr[`EER_SEL_LOCK]) begin
                           n.spec_area = eer_pkg::area_lock;
                        end else begin
                           n.spec_area = eer_pkg::area_sector;
                           n.sec_ptr   = full_addr[`EER_SEC_MSB:0];
                        end
                     end
                     default: begin
                        n.sda_oe_n = ~wr_ack;
                        if (!q.special) begin
                           n.main_ptr = eer_page_inc(q.main_ptr);
                        end
                     end
                  endcase
               end
            end
            eer_pkg::st_dev_ack: begin
               if (scl_fall) begin
                  if (q.shreg[`EER_RW_BIT]) begin
                     n.state    = eer_pkg::st_tx;
                     n.shreg    = tx_byte;
                     n.sda_oe_n = tx_byte[`EER_BYTE_W-1];
                     n.bit_cnt  = `EER_CNT_ONE;
                  end else begin
                     n.state    = eer_pkg::st_rx;
                     n.sda_oe_n = 1'b1;
                  end
               end
            end
            eer_pkg::st_rx_ack: begin
               if (scl_fall) begin
                  n.state    = eer_pkg::st_rx;
                  n.sda_oe_n = 1'b1;
               end
            end
            eer_pkg::st_tx: begin
               if (byte_done) begin
                  n.state    = eer_pkg::st_tx_ack;
                  n.sda_oe_n = 1'b1;
               end else if (scl_fall) begin
                  n.shreg    = {q.shreg[`EER_BYTE_W-2:0], 1'b0};
                  n.sda_oe_n = q.shreg[`EER_BYTE_W-2];
                  n.bit_cnt  = `EER_CNT_W'(q.bit_cnt + `EER_CNT_ONE);
               end
            end
            // The pointer moves at the acknowledge slot of every byte sent, the refused last one too.
            // The next fetch must come back within one clock-high time, or a stale byte goes out.
            eer_pkg::st_tx_ack: begin
               if (scl_rise) begin
                  n.main_ptr = nxt_main;
                  n.sec_ptr  = nxt_sec;
                  n.uid_ptr  = nxt_uid;
                  if (q.sda_s2) begin
                     n.state = eer_pkg::st_wait;
                  end else if (q.rd_area != eer_pkg::area_lock) begin
                     n.req_t    = ~q.req_t;
                     n.req_area = q.rd_area;
                     n.req_addr = eer_area_addr(q.rd_area, nxt_main, nxt_sec, nxt_uid);
                  end
               end else if (scl_fall) begin
                  n.state    = eer_pkg::st_tx;
                  n.shreg    = tx_byte;
                  n.sda_oe_n = tx_byte[`EER_BYTE_W-1];
                  n.bit_cnt  = `EER_CNT_ONE;
               end
            end
            // A refused address or a sent byte left unacknowledged parks here until the next start or stop.
            eer_pkg::st_wait: begin
               n.sda_oe_n = 1'b1;
            end
            default: begin
               n.state    = eer_pkg::st_idle;
               n.sda_oe_n = 1'b1;
            end
         endcase
      end
   end

   // Reset is taken at once but let go only on an edge of each clock, so no flop sees its release mid-setup.
   always_ff @(posedge clk_link or posedge reset) begin
      if (reset) begin
         link_rst_ff <= 2'h3;
      end else begin
         link_rst_ff <= {link_rst_ff[0], 1'h0};
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         sys_rst_ff <= 2'h3;
      end else begin
         sys_rst_ff <= {sys_rst_ff[0], 1'h0};
      end
   end

   assign link_rst = link_rst_ff[1];
   assign sys_rst  = sys_rst_ff[1];

   // Pin stages start at the idle bus level, so leaving reset shows no false edge.
   always_ff @(posedge clk_link or posedge link_rst) begin
      if (link_rst) begin
         q          <= '0;
         q.scl_s1   <= 1'h1;
         q.scl_s2   <= 1'h1;
         q.scl_s3   <= 1'h1;
         q.sda_s1   <= 1'h1;
         q.sda_s2   <= 1'h1;
         q.sda_s3   <= 1'h1;
         q.sda_oe_n <= 1'b1;
      end else begin
         q <= n;
      end
   end

   // Request address and area stay still from the toggle until the next one, so they cross as a held bus.
   always_comb begin
      ns           = qs;
      ns.req_s1    = q.req_t;
      ns.req_s2    = qs.req_s1;
      ns.req_s3    = qs.req_s2;
      ns.mem_rd_en = 1'b0;
      ns.rd_pend   = 1'b0;
      if (qs.req_s2 != qs.req_s3) begin
         ns.mem_rd_en = 1'b1;
         ns.rd_pend   = 1'b1;
      end
      if (qs.rd_pend) begin
         ns.rdata = mem_rd_data;
         ns.ack_t = ~qs.ack_t;
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         qs <= '0;
      end else begin
         qs <= ns;
      end
   end

   // The pin is open drain: only a low is ever driven, a one is left to the pull-up.
   assign sda_out     = 1'b0;
   assign sda_oe_n    = q.sda_oe_n;
   assign mem_rd_en   = qs.mem_rd_en;
   assign mem_rd_area = q.req_area;
   assign mem_rd_addr = q.req_addr;

endmodule : eer_read_path

//--- common/eer_params.svh
// Purpose: Named constants of the serial EEPROM read path.
// Assumes: Included by the package and by the design module.
// Notes:   Definitions only.
`ifndef EER_PARAMS_SVH
`define EER_PARAMS_SVH
`define EER_CODE_MAIN     4'ha
`define EER_CODE_SPECIAL  4'hb
`define EER_CODE_LSB      4
`define EER_CS_LSB        1
`define EER_RW_BIT        0
`define EER_ADDR_W        16
`define EER_BYTE_W        8
`define EER_CS_W          3
`define EER_CNT_W         4
`define EER_BITS_PER_BYTE 4'h8
`define EER_CNT_ONE       4'h1
`define EER_SEL_UID       9
`define EER_SEL_LOCK      10
`define EER_SEC_MSB       6
`define EER_SEC_W         7
`define EER_UID_MSB       3
`define EER_UID_W         4
`define EER_PAGE_W        7
`define EER_LOCK_BIT      1
`define EER_IDX_HI        2'h0
`define EER_IDX_LO        2'h1
`define EER_IDX_DATA      2'h2
`endif

//--- common/eer_pkg.sv
// Purpose: Types of the serial EEPROM read path.
// Assumes: Constants come from eer_params.svh.
// Notes:   One struct per clock domain holds all state of that domain except its reset synchronizer.
`include "eer_params.svh"
package eer_pkg;
   typedef enum logic [2:0] {
      st_idle    = 3'h0,
      st_dev     = 3'h1,
      st_dev_ack = 3'h3,
      st_tx      = 3'h2,
      st_tx_ack  = 3'h6,
      st_rx      = 3'h7,
      st_rx_ack  = 3'h5,
      st_wait    = 3'h4
   } eer_state_type;

   typedef enum logic [1:0] {
      area_main   = 2'h0,
      area_sector = 2'h1,
      area_uid    = 2'h2,
      area_lock   = 2'h3
   } eer_area_type;

   typedef struct packed {
      logic                     scl_s1;
      logic                     scl_s2;
      logic                     scl_s3;
      logic                     sda_s1;
      logic                     sda_s2;
      logic                     sda_s3;
      logic [`EER_CS_W-1:0]     cs_s1;
      logic [`EER_CS_W-1:0]     cs_s2;
      logic                     lock_s1;
      logic                     lock_s2;
      logic                     ack_s1;
      logic                     ack_s2;
      logic                     ack_s3;
      eer_state_type            state;
      logic [`EER_CNT_W-1:0]    bit_cnt;
      logic [`EER_BYTE_W-1:0]   shreg;
      logic                     special;
      logic [1:0]               byte_idx;
      logic [`EER_BYTE_W-1:0]   waddr_hi;
      logic [`EER_ADDR_W-1:0]   main_ptr;
      logic [`EER_SEC_W-1:0]    sec_ptr;
      logic [`EER_UID_W-1:0]    uid_ptr;
      eer_area_type             spec_area;
      eer_area_type             rd_area;
      logic                     req_t;
      eer_area_type             req_area;
      logic [`EER_ADDR_W-1:0]   req_addr;
      logic [`EER_BYTE_W-1:0]   fetched;
      logic                     sda_oe_n;
   } eer_link_type;

   typedef struct packed {
      logic                     req_s1;
      logic                     req_s2;
      logic                     req_s3;
      logic                     rd_pend;
      logic                     mem_rd_en;
      logic [`EER_BYTE_W-1:0]   rdata;
      logic                     ack_t;
   } eer_sys_type;
endpackage : eer_pkg

//--- dv/eer_read_path_props.sv
// Purpose: Port-level checks of the EEPROM read path.
// Assumes: SDA has a pull-up; the two clocks are unrelated.
// Notes:   Bus idle is tracked from start and stop seen on the pins.
`timescale 1ns/1ns
`include "eer_params.svh"
module eer_read_path_props (
   input wire logic                   clk_sys,
   input wire logic                   reset,
   input wire logic                   clk_link,
   input wire logic                   scl_in,
   input wire logic                   sda_in,
   input wire logic                   sda_oe_n,
   input wire logic                   mem_rd_en,
   input wire eer_pkg::eer_area_type  mem_rd_area,
   input wire logic [`EER_ADDR_W-1:0] mem_rd_addr
);
   logic scl_ff;
   logic sda_ff;
   logic idle_ff;
   // An SDA edge while SCL stays high is a stop (rise) or a start (fall).
   always_ff @(posedge clk_link or posedge reset) begin
      if (reset) begin
         scl_ff  <= 1'b1;
         sda_ff  <= 1'b1;
         idle_ff <= 1'b1;
      end else begin
         scl_ff <= scl_in;
         sda_ff <= sda_in;
         if (scl_in && scl_ff && sda_in != sda_ff) begin
            idle_ff <= sda_in;
         end
      end
   end
   en_pulse_a: assert property (@(posedge clk_sys) disable iff (reset)
      mem_rd_en |=> !mem_rd_en [*8]) else $error("fetch requests too close");
   req_hold_a: assert property (@(posedge clk_sys) disable iff (reset)
      mem_rd_en |=> $stable(mem_rd_area) && $stable(mem_rd_addr)) else $error("fetch address moved");
   area_legal_a: assert property (@(posedge clk_sys) disable iff (reset)
      mem_rd_en |-> mem_rd_area != eer_pkg::area_lock) else $error("lock status fetched from memory");
   uid_range_a: assert property (@(posedge clk_sys) disable iff (reset)
      mem_rd_en && mem_rd_area == eer_pkg::area_uid |-> mem_rd_addr[15:4] == 12'h000) else $error("id address wide");
   sec_range_a: assert property (@(posedge clk_sys) disable iff (reset)
      mem_rd_en && mem_rd_area == eer_pkg::area_sector |-> mem_rd_addr[15:7] == 9'h000) else $error("sector wide");
   fetch_busy_a: assert property (@(posedge clk_sys) disable iff (reset)
      mem_rd_en |-> !idle_ff) else $error("fetch while bus idle");
   oe_scl_low_a: assert property (@(posedge clk_link) disable iff (reset)
      $changed(sda_oe_n) |-> !scl_in) else $error("data drive changed with clock high");
   idle_release_a: assert property (@(posedge clk_link) disable iff (reset)
      idle_ff |-> sda_oe_n) else $error("data driven while bus idle");
   cov_main: cover property (@(posedge clk_sys) mem_rd_en && mem_rd_area == eer_pkg::area_main);
   cov_uid: cover property (@(posedge clk_sys) mem_rd_en && mem_rd_area == eer_pkg::area_uid);
   cov_sec: cover property (@(posedge clk_sys) mem_rd_en && mem_rd_area == eer_pkg::area_sector);
endmodule : eer_read_path_props
bind eer_read_path eer_read_path_props u_props (.clk_sys, .reset, .clk_link, .scl_in, .sda_in,
   .sda_oe_n, .mem_rd_en, .mem_rd_area, .mem_rd_addr);

//--- dv/eer_bus_ctrl.sv
// Purpose: Two-wire bus controller model for the read path.
// Assumes: One task runs at a time; SDA has a pull-up.
// Notes:   Pins change only after a falling edge of clk_sys.
`timescale 1ns/1ns
module eer_bus_ctrl (
   input  wire logic clk_sys,
   input  wire logic sda_wire,
   output logic      scl,
   output logic      sda_low
);
   int lo_wait = 5;
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   task automatic hp(input int n);
      repeat (n) @(negedge clk_sys);
   endtask : hp
   // SDA is lifted while SCL is low, so a repeated start never looks like a stop.
   task automatic start();
      sda_low = 1'b0;
      hp(5);
      scl = 1'b1;
      hp(10);
      sda_low = 1'b1;
      hp(10);
      scl = 1'b0;
      hp(5);
   endtask : start
   task automatic stop();
      sda_low = 1'b1;
      hp(5);
      scl = 1'b1;
      hp(10);
      sda_low = 1'b0;
      hp(10);
   endtask : stop
   // Eight bits MSB first, then the acknowledge slot; a one is sent by releasing SDA.
   task automatic xfer(input logic [8:0] d, output logic [8:0] q);
      for (int i = 8; i >= 0; i--) begin
         sda_low = !d[i];
         hp(lo_wait);
         scl = 1'b1;
         hp(5);
         q[i] = sda_wire;
         hp(5);
         scl = 1'b0;
         hp(5);
      end
   endtask : xfer
endmodule : eer_bus_ctrl

//--- dv/eer_read_path_tb.sv
// Purpose: Self-checking bench for the EEPROM read path.
// Assumes: Memory contents are a fixed function of area and address.
// Notes:   Pointers are tracked here, apart from the design.
`timescale 1ns/1ns
`include "eer_params.svh"
module eer_read_path_tb;
   logic                   clk_sys = 1'b0;
   logic                   clk_link = 1'b0;
   logic                   reset = 1'b1;
   logic [2:0]             cs = 3'h0;
   logic                   locked = 1'b0;
   logic                   scl;
   logic                   sda_low;
   logic                   sda_w;
   logic                   sda_oe_n;
   logic                   sda_out;
   logic                   mem_rd_en;
   eer_pkg::eer_area_type  mem_rd_area;
   logic [`EER_ADDR_W-1:0] mem_rd_addr;
   logic [7:0]             mem_rd_data;
   logic [15:0]            mptr;
   logic [15:0]            sptr;
   int                     n_mismatch = 0;
   int                     checks = 0;
   always #20 clk_sys = !clk_sys;
   always #15 clk_link = !clk_link;
   assign sda_w = !(sda_low || (!sda_oe_n && !sda_out));
   function automatic logic [7:0] mem_byte(input eer_pkg::eer_area_type a, input logic [15:0] x);
      return x[7:0] ^ {x[14:8], x[15]} ^ {6'h0, a};
   endfunction : mem_byte
   assign mem_rd_data = mem_byte(mem_rd_area, mem_rd_addr);
   eer_read_path DUT (.clk_sys, .reset, .clk_link, .scl_in(scl), .sda_in(sda_w), .sda_out, .sda_oe_n,
      .chip_select_bit2(cs[2]), .chip_select_lock_flag_bit(cs[1]), .chip_select_bit0(cs[0]),
      .sector_locked(locked), .mem_rd_en, .mem_rd_area, .mem_rd_addr, .mem_rd_data);
   eer_bus_ctrl ctrl (.clk_sys, .sda_wire(sda_w), .scl, .sda_low);
   task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : chk_byte
   task automatic chk_ack(input string what, input logic exp, input logic got);
      chk_byte(what, {7'h0, exp}, {7'h0, got});
   endtask : chk_ack
   task automatic put(input logic [7:0] b, input logic ack_exp);
      logic [8:0] q;
      ctrl.xfer({b, 1'b1}, q);
      chk_ack("ack", ack_exp, !q[0]);
   endtask : put
   task automatic point(input logic [3:0] code, input logic [15:0] a);
      ctrl.start();
      put({code, cs, 1'b0}, 1'b1);
      put(a[15:8], 1'b1);
      put(a[7:0], 1'b1);
   endtask : point
   // The pointer also advances past the last byte, the one left unacknowledged.
   task automatic get(input logic [3:0] code, input eer_pkg::eer_area_type ar, input int n,
                      input logic [15:0] m, inout logic [15:0] p);
      logic [8:0] q;
      ctrl.start();
      put({code, cs, 1'b1}, 1'b1);
      for (int i = 0; i < n; i++) begin
         ctrl.xfer({8'hff, i == n - 1}, q);
         chk_byte("data", ar == eer_pkg::area_lock ? {6'h0, locked, 1'b0} : mem_byte(ar, p), q[8:1]);
         p = (p + 16'h0001) & m;
      end
      ctrl.stop();
   endtask : get
   task automatic results();
      $display("checks %0d, mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : results
   initial begin
      repeat (90000) @(posedge clk_sys);
      n_mismatch++;
      results();
   end
   initial begin
      logic [15:0] a;
      a = 16'($urandom(32'h3108));
      cs = 3'($urandom_range(7));
      repeat (6) @(negedge clk_sys);
      reset = 1'b0;
      repeat (20) @(negedge clk_sys);
      for (int k = 0; k < 5; k++) begin
         mptr = k == 0 ? 16'hfffe : 16'($urandom);
         ctrl.lo_wait = 5 + int'($urandom_range(8));
         point(4'ha, mptr);
         get(4'ha, eer_pkg::area_main, k == 0 ? 4 : 1 + int'($urandom_range(2)), 16'hffff, mptr);
      end
      get(4'ha, eer_pkg::area_main, 2, 16'hffff, mptr);
      // A written byte steps the pointer inside its page only, so a page's last byte wraps to its first.
      mptr = {mptr[15:7], 7'h7f};
      point(4'ha, mptr);
      put(8'($urandom), 1'b1);
      mptr = {mptr[15:7], 7'h00};
      get(4'ha, eer_pkg::area_main, 1, 16'hffff, mptr);
      // A dummy write cut short after its first address byte must leave the pointer alone.
      ctrl.start();
      put({4'ha, cs, 1'b0}, 1'b1);
      put(~mptr[15:8], 1'b1);
      get(4'ha, eer_pkg::area_main, 1, 16'hffff, mptr);
      for (int k = 0; k < 2; k++) begin
         ctrl.start();
         put(k == 0 ? {4'ha, ~cs, 1'b1} : {4'h9, cs, 1'b1}, 1'b0);
         ctrl.stop();
      end
      a = 16'($urandom) | 16'h0200;
      point(4'hb, {a[15:4], 4'he});
      sptr = 16'h000e;
      get(4'hb, eer_pkg::area_uid, 4, 16'h000f, sptr);
      a = 16'($urandom) & 16'hf9ff;
      point(4'hb, {a[15:7], 7'h7e});
      sptr = 16'h007e;
      get(4'hb, eer_pkg::area_sector, 3, 16'h007f, sptr);
      for (int l = 0; l < 2; l++) begin
         locked = l[0];
         a = (16'($urandom) & 16'hf9ff) | 16'h0400;
         point(4'hb, a);
         get(4'hb, eer_pkg::area_lock, 3, 16'h0000, sptr);
         point(4'hb, a & 16'hf9ff);
         put(8'($urandom), !locked);
         ctrl.start();
         ctrl.stop();
      end
      get(4'ha, eer_pkg::area_main, 1, 16'hffff, mptr);
      results();
   end
endmodule : eer_read_path_tb
